// ---- design/ddmc_pkg.sv ----
// constants and types of the dual dac mode control register bank
// How it works
// - bidir bit lets data pin drive reads
// - bit order select, msb first default
// - soft reset spares address zero; pin resets all
// - sleep stops outputs, power-down stops all else but the serial port
// - resistor mode: separate or shared reference
// - lock bit reads pll lock when enabled
// - interpolation rate field one to eight times
// - modulation mode field none to fs/8
// - zero stuffing enable bit
// - real mix default, zero couples modulators
// - complex rotation sign selects rejected image
// - two-port shared pin shows lock or clock
// - input coding twos complement or binary
// - two-port or interleaved one-port input
// - clock inversions and stronger clock driver
// - channel select polarity and pair order
// - data clock to shared pin or serial out
// - pll output divider one to eight
// - pll enable bit, off by default
// - charge pump bias automatic or manual
// - per channel fine and coarse gain
// - per channel offset and its direction
// - serial port reads and writes every register
package ddmc_pkg;
    localparam int NUM_REGS = 13;
    localparam logic [4:0] A_SPC = 5'h00;
    localparam logic [4:0] A_IMC = 5'h01;
    localparam logic [4:0] A_IDF = 5'h02;
    localparam logic [4:0] A_CRD = 5'h03;
    localparam logic [4:0] A_PCP = 5'h04;
    localparam logic [4:0] A_IFG = 5'h05;
    localparam logic [4:0] A_ICG = 5'h06;
    localparam logic [4:0] A_IOH = 5'h07;
    localparam logic [4:0] A_IOL = 5'h08;
    localparam logic [4:0] A_QFG = 5'h09;
    localparam logic [4:0] A_QCG = 5'h0a;
    localparam logic [4:0] A_QOH = 5'h0b;
    localparam logic [4:0] A_QOL = 5'h0c;
    localparam int B_BIDIR = 7, B_LSBF = 6, B_SRST = 5, B_SLEEP = 4, B_PDN = 3, B_RMODE = 2, B_LOCK = 1;
    localparam int B_INTERP = 6, B_MOD = 4, B_ZSTUFF = 3, B_REALMIX = 2, B_IMGSEL = 1, B_PIN8CLK = 0;
    localparam int B_BINARY = 7, B_ONEPORT = 6, B_DCSTRONG = 5, B_DCINV = 4, B_OPCINV = 2;
    localparam int B_SELINV = 1, B_QIORD = 0;
    localparam int B_CLKSDO = 7, B_PLLDIV = 0, B_PLLEN = 7, B_CPMAN = 6, B_CPBIAS = 0, B_OFFDIR = 7;
    localparam int B_RW = 7, B_NB = 5;
    // packed high address first
    localparam logic [NUM_REGS-1:0][7:0] WR_MASK = {8'h83, 8'hff, 8'h0f, 8'hff, 8'h83, 8'hff, 8'h0f,
                                                    8'hff, 8'hc7, 8'h83, 8'hf7, 8'hff, 8'hdc};
    localparam logic [NUM_REGS-1:0][7:0] RST_VAL = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                                    8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
    typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_HOLD} ddmc_ser_e;
    typedef struct packed {
        ddmc_ser_e                   st;
        logic                        rd;
        logic [4:0]                  addr;
        logic [1:0]                  left;
        logic [NUM_REGS-1:0][7:0]    regs;
        logic [7:0]                  tx;
        logic                        restart;
        logic                        sdio_oe;
        logic                        sdo_oe;
    } ddmc_top_s;
    typedef struct packed {
        logic       prev;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic       done;
        logic [7:0] rx;
        logic       bit_out;
    } ddmc_eng_s;
    typedef struct packed {
        logic pin8;
        logic opc;
        logic sdo;
    } ddmc_rte_s;
endpackage

// ---- design/ddmc_link_if.sv ----
// carrier between the register bank, its serial engine and the clock router
`timescale 1ns/1ps
interface ddmc_link_if;
    logic       lsb_first;
    logic [7:0] tx_byte;
    logic       byte_done;
    logic [7:0] rx_byte;
    logic       tx_bit;
    logic       pll_lock;
    logic       data_clk;
    logic       one_port;
    logic       pin8_clk;
    logic       dc_inv;
    logic       opc_inv;
    logic       clk_sdo;
    logic       pdn;
    modport eng (input lsb_first, tx_byte, output byte_done, rx_byte, tx_bit);
    modport rte (input pll_lock, data_clk, one_port, pin8_clk, dc_inv, opc_inv, clk_sdo, pdn, tx_bit);
endinterface

// ---- design/ddmc_shift.sv ----
// serial byte engine: samples on rising sclk, shifts out on falling sclk
`timescale 1ns/1ps
module ddmc_shift (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // serial pins
    input  wire logic sclk,
    input  wire logic csb_n,
    input  wire logic sdi,
    // bank side
    ddmc_link_if.eng  link
);
    ddmc_pkg::ddmc_eng_s q, n;
    logic [7:0] sh_in;

    always_comb
    begin
        n = q;
        n.done = 1'b0;
        n.prev = sclk;
        sh_in = link.lsb_first ? {sdi, q.sh[7:1]} : {q.sh[6:0], sdi};
        if (csb_n)
        begin
            // a fresh select always restarts at the instruction byte
            n.cnt = 3'h0;
        end
        else if (sclk && !q.prev)
        begin
            n.sh = sh_in;
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7)
            begin
                n.done = 1'b1;
                n.rx = sh_in;
            end
        end
        else if (!sclk && q.prev)
        begin
            n.bit_out = link.lsb_first ? link.tx_byte[q.cnt] : link.tx_byte[3'h7 - q.cnt];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            q <= '0;
        else
            q <= n;
    end

    assign link.byte_done = q.done;
    assign link.rx_byte   = q.rx;
    assign link.tx_bit    = q.bit_out;

    a_byte_count: assert property (@(posedge ref_clk) disable iff (srst)
        q.done |-> $past(q.cnt) == 3'h7) else $error("byte done without eight bits");
endmodule

// ---- design/ddmc_clk_route.sv ----
// routes lock and data rate clock onto the shared pins
`timescale 1ns/1ps
module ddmc_clk_route (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // bank side
    ddmc_link_if.rte  link,
    // pins
    output logic      pin8_q,
    output logic      opc_q,
    output logic      sdo_q
);
    ddmc_pkg::ddmc_rte_s q, n;
    logic dclk;

    always_comb
    begin
        n = q;
        // power-down silences the clocks, the serial port stays alive
        dclk = link.data_clk & ~link.pdn;
        if (!link.clk_sdo && (link.one_port || link.pin8_clk))
            n.pin8 = dclk ^ link.dc_inv;
        else
            n.pin8 = link.pll_lock;
        n.opc = dclk ^ link.opc_inv;
        n.sdo = link.clk_sdo ? dclk : link.tx_bit;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            q <= '0;
        else
            q <= n;
    end

    assign pin8_q = q.pin8;
    assign opc_q  = q.opc;
    assign sdo_q  = q.sdo;

    a_pin8_lock: assert property (@(posedge ref_clk) disable iff (srst)
        (!link.one_port && !link.pin8_clk) |=> pin8_q == $past(link.pll_lock))
        else $error("shared pin not showing lock");
    a_opc_invert: assert property (@(posedge ref_clk) disable iff (srst)
        1'b1 |=> opc_q == $past((link.data_clk & ~link.pdn) ^ link.opc_inv))
        else $error("one-port clock polarity wrong");
endmodule

// ---- design/ddmc_regs.sv ----
// top of the dual dac mode control register bank behind the serial port
`timescale 1ns/1ps
module ddmc_regs #(
    parameter int NREG = ddmc_pkg::NUM_REGS
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // serial port
    input  wire logic       spi_sclk,
    input  wire logic       spi_csb_n,
    input  wire logic       sdio_in,
    output logic            sdio_out,
    output logic            sdio_oe,
    output logic            serial_data_out_pin,
    output logic            serial_data_out_pin_oe,
    // analog and pll status
    input  wire logic       pll_lock_in,
    input  wire logic       data_rate_clk_in,
    // clock pins
    output logic            data_rate_clock_out,
    output logic            single_port_clock_out,
    // power and reference
    output logic            chip_restart,
    output logic            dac_sleep,
    output logic            power_down,
    output logic            resistor_mode_select,
    // datapath modes
    output logic [1:0]      interp_rate,
    output logic [1:0]      mod_mode,
    output logic            zero_stuff_en,
    output logic            real_mix,
    output logic            image_sel,
    output logic            straight_binary,
    output logic            one_port_mode,
    output logic            data_rate_clock_out_strong,
    output logic            channel_select_invert,
    output logic            qi_pair_order,
    // pll
    output logic [1:0]      pll_div,
    output logic            pll_en,
    output logic            cp_manual,
    output logic [2:0]      cp_bias,
    // channel trims
    output logic [7:0]      i_fine_gain,
    output logic [3:0]      i_coarse_gain,
    output logic [9:0]      i_offset,
    output logic            i_offset_dir,
    output logic [7:0]      q_fine_gain,
    output logic [3:0]      q_coarse_gain,
    output logic [9:0]      q_offset,
    output logic            q_offset_dir
);
    if (NREG != ddmc_pkg::NUM_REGS)
    begin : g_bad_nreg
        $error("register count must match the map");
    end

    ddmc_pkg::ddmc_top_s q, n;
    ddmc_link_if link ();
    logic       lock_rd;
    logic [7:0] wmask;
    logic       bidir;

    // lock reads zero while the pll is off
    assign lock_rd = q.regs[ddmc_pkg::A_PCP][ddmc_pkg::B_PLLEN] & pll_lock_in;
    assign bidir   = q.regs[ddmc_pkg::A_SPC][ddmc_pkg::B_BIDIR];

    function automatic logic [7:0] rd_val(input ddmc_pkg::ddmc_top_s s, input logic [4:0] a, input logic lk);
        rd_val = 8'h00;
        if (a < 5'(ddmc_pkg::NUM_REGS))
            rd_val = s.regs[a] & ddmc_pkg::WR_MASK[a];
        if (a == ddmc_pkg::A_SPC)
            rd_val[ddmc_pkg::B_LOCK] = lk;
    endfunction

    always_comb
    begin
        n = q;
        n.restart = 1'b0;
        wmask = 8'h00;
        if (q.addr < 5'(ddmc_pkg::NUM_REGS))
            wmask = ddmc_pkg::WR_MASK[q.addr];
        if (spi_csb_n)
        begin
            // an aborted byte never reaches a register
            n.st = ddmc_pkg::ST_INSTR;
        end
        else if (link.byte_done)
        begin
            unique case (q.st)
                ddmc_pkg::ST_INSTR:
                begin
                    n.rd = link.rx_byte[ddmc_pkg::B_RW];
                    n.left = link.rx_byte[ddmc_pkg::B_NB +: 2];
                    n.addr = link.rx_byte[4:0];
                    n.tx = rd_val(q, link.rx_byte[4:0], lock_rd);
                    n.st = ddmc_pkg::ST_DATA;
                end
                ddmc_pkg::ST_DATA:
                begin
                    if (!q.rd && wmask != 8'h00)
                    begin
                        n.regs[q.addr] = (q.regs[q.addr] & ~wmask) | (link.rx_byte & wmask);
                        if (q.addr == ddmc_pkg::A_SPC && link.rx_byte[ddmc_pkg::B_SRST])
                        begin
                            // address zero keeps its new value, the rest go to defaults
                            for (int i = 1; i < ddmc_pkg::NUM_REGS; i++)
                                n.regs[i] = ddmc_pkg::RST_VAL[i];
                            n.restart = 1'b1;
                        end
                    end
                    n.addr = q.addr + 5'h01;
                    n.left = q.left - 2'h1;
                    n.tx = rd_val(n, q.addr + 5'h01, lock_rd);
                    if (q.left == 2'h0)
                        n.st = ddmc_pkg::ST_HOLD;
                end
                ddmc_pkg::ST_HOLD:
                begin
                    n.st = ddmc_pkg::ST_HOLD;
                end
            endcase
        end
        n.sdio_oe = !spi_csb_n && n.st == ddmc_pkg::ST_DATA && n.rd && bidir;
        n.sdo_oe = n.regs[ddmc_pkg::A_CRD][ddmc_pkg::B_CLKSDO] ||
                   (!spi_csb_n && n.st == ddmc_pkg::ST_DATA && n.rd && !bidir);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.regs <= ddmc_pkg::RST_VAL;
        end
        else
        begin
            q <= n;
        end
    end

    // link wiring
    assign link.lsb_first = q.regs[ddmc_pkg::A_SPC][ddmc_pkg::B_LSBF];
    assign link.tx_byte   = q.tx;
    assign link.pll_lock  = lock_rd;
    assign link.data_clk  = data_rate_clk_in;
    assign link.one_port  = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_ONEPORT];
    assign link.pin8_clk  = q.regs[ddmc_pkg::A_IMC][ddmc_pkg::B_PIN8CLK];
    assign link.dc_inv    = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_DCINV];
    assign link.opc_inv   = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_OPCINV];
    assign link.clk_sdo   = q.regs[ddmc_pkg::A_CRD][ddmc_pkg::B_CLKSDO];
    assign link.pdn       = q.regs[ddmc_pkg::A_SPC][ddmc_pkg::B_PDN];

    ddmc_shift u_shift (
        .ref_clk (ref_clk),
        .srst    (srst),
        .sclk    (spi_sclk),
        .csb_n   (spi_csb_n),
        .sdi     (sdio_in),
        .link    (link)
    );

    ddmc_clk_route u_route (
        .ref_clk (ref_clk),
        .srst    (srst),
        .link    (link),
        .pin8_q  (data_rate_clock_out),
        .opc_q   (single_port_clock_out),
        .sdo_q   (serial_data_out_pin)
    );

    // serial outputs
    assign sdio_out               = link.tx_bit;
    assign sdio_oe                = q.sdio_oe;
    assign serial_data_out_pin_oe = q.sdo_oe;

    // control fields straight from the register flops
    assign chip_restart          = q.restart;
    assign dac_sleep             = q.regs[ddmc_pkg::A_SPC][ddmc_pkg::B_SLEEP];
    assign power_down            = q.regs[ddmc_pkg::A_SPC][ddmc_pkg::B_PDN];
    assign resistor_mode_select  = q.regs[ddmc_pkg::A_SPC][ddmc_pkg::B_RMODE];
    assign interp_rate           = q.regs[ddmc_pkg::A_IMC][ddmc_pkg::B_INTERP +: 2];
    assign mod_mode              = q.regs[ddmc_pkg::A_IMC][ddmc_pkg::B_MOD +: 2];
    assign zero_stuff_en         = q.regs[ddmc_pkg::A_IMC][ddmc_pkg::B_ZSTUFF];
    assign real_mix              = q.regs[ddmc_pkg::A_IMC][ddmc_pkg::B_REALMIX];
    assign image_sel             = q.regs[ddmc_pkg::A_IMC][ddmc_pkg::B_IMGSEL];
    assign straight_binary       = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_BINARY];
    assign one_port_mode         = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_ONEPORT];
    assign data_rate_clock_out_strong        = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_DCSTRONG];
    assign channel_select_invert = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_SELINV];
    assign qi_pair_order         = q.regs[ddmc_pkg::A_IDF][ddmc_pkg::B_QIORD];
    assign pll_div               = q.regs[ddmc_pkg::A_CRD][ddmc_pkg::B_PLLDIV +: 2];
    assign pll_en                = q.regs[ddmc_pkg::A_PCP][ddmc_pkg::B_PLLEN];
    assign cp_manual             = q.regs[ddmc_pkg::A_PCP][ddmc_pkg::B_CPMAN];
    assign cp_bias               = q.regs[ddmc_pkg::A_PCP][ddmc_pkg::B_CPBIAS +: 3];
    assign i_fine_gain           = q.regs[ddmc_pkg::A_IFG];
    assign i_coarse_gain         = q.regs[ddmc_pkg::A_ICG][3:0];
    assign i_offset              = {q.regs[ddmc_pkg::A_IOH], q.regs[ddmc_pkg::A_IOL][1:0]};
    assign i_offset_dir          = q.regs[ddmc_pkg::A_IOL][ddmc_pkg::B_OFFDIR];
    assign q_fine_gain           = q.regs[ddmc_pkg::A_QFG];
    assign q_coarse_gain         = q.regs[ddmc_pkg::A_QCG][3:0];
    assign q_offset              = {q.regs[ddmc_pkg::A_QOH], q.regs[ddmc_pkg::A_QOL][1:0]};
    assign q_offset_dir          = q.regs[ddmc_pkg::A_QOL][ddmc_pkg::B_OFFDIR];

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence s_soft_rst_write;
        q.st == ddmc_pkg::ST_DATA && !q.rd && q.addr == ddmc_pkg::A_SPC && link.byte_done && !spi_csb_n &&
        link.rx_byte[ddmc_pkg::B_SRST];
    endsequence

    sequence s_instr_taken;
        q.st == ddmc_pkg::ST_INSTR && link.byte_done && !spi_csb_n;
    endsequence

    a_sdio_drive: assert property (sdio_oe |-> bidir && q.rd && q.st == ddmc_pkg::ST_DATA)
        else $error("data pin driven outside a bidir read");
    a_sdo_quiet: assert property (serial_data_out_pin_oe && !link.clk_sdo |-> !bidir && q.rd)
        else $error("serial out driven in bidir mode");
    a_soft_reset: assert property (s_soft_rst_write |=> chip_restart && q.regs[NREG-1:1] ==
        ddmc_pkg::RST_VAL[NREG-1:1] && q.regs[0][ddmc_pkg::B_SRST] == 1'b0)
        else $error("soft reset did not restore defaults");
    a_pin_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
        $past(srst) |-> q.regs == ddmc_pkg::RST_VAL && !chip_restart)
        else $error("reset pin left a register off default");
    a_lock_read: assert property (s_instr_taken ##0 (link.rx_byte[4:0] == ddmc_pkg::A_SPC) |=>
        q.tx[ddmc_pkg::B_LOCK] == $past(lock_rd)) else $error("lock readback wrong");
    a_write_lands: assert property (q.st == ddmc_pkg::ST_DATA && !q.rd && link.byte_done && !spi_csb_n &&
        q.addr == ddmc_pkg::A_IFG |=> i_fine_gain == $past(link.rx_byte))
        else $error("write did not land");
    // the byte count is checked in two steps, so no wait of open length is needed between them
    sequence s_last_data;
        q.st == ddmc_pkg::ST_DATA && q.left == 2'h0 && link.byte_done && !spi_csb_n;
    endsequence

    a_burst_end: assert property (s_instr_taken ##0 (link.rx_byte[6:5] == 2'h0) |=>
        q.st == ddmc_pkg::ST_DATA && q.left == 2'h0) else $error("single byte count not taken");
    a_last_byte: assert property (s_last_data |=> q.st == ddmc_pkg::ST_HOLD)
        else $error("transfer did not end after its last byte");

    for (genvar g = 0; g < ddmc_pkg::NUM_REGS; g++)
    begin : g_unused
        a_unused_zero: assert property ((q.regs[g] & ~ddmc_pkg::WR_MASK[g]) == 8'h00)
            else $error("undescribed bit holds a one");
    end
endmodule

// ---- verif/ddmc_host.sv ----
// host serial master model that programs and reads the register bank
`timescale 1ns/1ps
module ddmc_host (
    // clock
    input  wire logic ref_clk,
    // serial lines
    output logic      sclk,
    output logic      csb_n,
    output logic      mosi,
    input  wire logic rx_line
);
    initial
    begin
        sclk = 1'b0;
        csb_n = 1'b1;
        mosi = 1'b0;
    end

    // each sclk level lasts several ref_clk cycles so the sampled port sees it
    task automatic shift(input logic [7:0] wb, input logic lsbf, input logic rel, input int nb,
                         output logic [7:0] rb);
        int idx;
        rb = 8'h00;
        for (int i = 0; i < nb; i++)
        begin
            idx = lsbf ? i : 7 - i;
            @(posedge ref_clk);
            sclk <= 1'b0;
            mosi <= rel ? ~mosi : wb[idx];          // released line toggles, never holds a stale bit
            repeat (4) @(posedge ref_clk);
            @(negedge ref_clk);
            rb[idx] = rx_line;
            @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (3) @(posedge ref_clk);
        end
    endtask

    // cut above zero sends only cut bits of each data byte before chip select drops
    task automatic xfer(input logic rd, input int n, input logic [4:0] a, input logic lsbf,
                        input logic [31:0] wd, input int cut, output logic [31:0] rdat);
        logic [7:0] rb;
        rdat = 32'h0;
        @(posedge ref_clk);
        csb_n <= 1'b0;
        shift({rd, 2'(n - 1), a}, lsbf, 1'b0, 8, rb);
        for (int k = 0; k < n; k++)
        begin
            shift(wd[8*k+:8], lsbf, rd, (cut > 0) ? cut : 8, rb);
            rdat[8*k+:8] = rb;
        end
        repeat (4) @(posedge ref_clk);
        sclk <= 1'b0;
        repeat (4) @(posedge ref_clk);
        csb_n <= 1'b1;
        mosi <= ~mosi;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the dual dac mode control register bank
`timescale 1ns/1ps
module tb;
    logic        ref_clk, srst, sclk, csb_n, mosi, idle_t, lock_in, dclk_in, lsb_mode, oe_a, oe_b;
    logic        sdio_out, sdio_oe, sdo_pin, sdo_oe;
    wire logic   sdio_in;
    wire logic   rx_line;
    int          n_mismatch, checks_done, cyc, n_restart;
    logic [31:0] rv;

    assign sdio_in = sdio_oe ? sdio_out : mosi;
    assign rx_line = sdio_oe ? sdio_out : (sdo_oe ? sdo_pin : idle_t);

    ddmc_host host (.ref_clk(ref_clk), .sclk(sclk), .csb_n(csb_n), .mosi(mosi), .rx_line(rx_line));

    ddmc_regs dut (
        .ref_clk(ref_clk), .srst(srst), .spi_sclk(sclk), .spi_csb_n(csb_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_out_pin(sdo_pin), .serial_data_out_pin_oe(sdo_oe),
        .pll_lock_in(lock_in), .data_rate_clk_in(dclk_in), .data_rate_clock_out(), .single_port_clock_out(),
        .chip_restart(), .dac_sleep(), .power_down(), .resistor_mode_select(), .interp_rate(), .mod_mode(),
        .zero_stuff_en(), .real_mix(), .image_sel(), .straight_binary(), .one_port_mode(), .data_rate_clock_out_strong(),
        .channel_select_invert(), .qi_pair_order(), .pll_div(), .pll_en(), .cp_manual(), .cp_bias(),
        .i_fine_gain(), .i_coarse_gain(), .i_offset(), .i_offset_dir(), .q_fine_gain(), .q_coarse_gain(),
        .q_offset(), .q_offset_dir()
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ceiling well above the roughly 13k cycles the scenarios need
    always @(posedge ref_clk)
    begin
        idle_t <= ~idle_t;
        cyc++;
        if (dut.chip_restart === 1'b1)
            n_restart++;
        if (sdio_oe === 1'b1)
            oe_a = 1'b1;
        if (sdo_oe === 1'b1)
            oe_b = 1'b1;
        if (cyc == 60000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input int n);
        logic [31:0] dummy;
        host.xfer(1'b0, n, a, lsb_mode, d, 0, dummy);
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [4:0] a, input int n, output logic [31:0] d);
        host.xfer(1'b1, n, a, lsb_mode, 32'h0, 0, d);
    endtask

    task automatic t_reset();
        chk("real_mix", 32'h1, dut.real_mix);
        chk("mode bits", 32'h0, {dut.interp_rate, dut.mod_mode, dut.pll_en, dut.one_port_mode});
        for (int a = 0; a < 13; a++)
        begin
            rd(5'(a), 1, rv);
            chk("reset value", {24'h0, ddmc_pkg::RST_VAL[a]}, rv);
        end
    endtask

    task automatic t_regs();
        logic [31:0] wd;
        logic [31:0] ex;
        int          a;
        for (int j = 0; j < 4; j++)
        begin
            a = (j == 3) ? 11 : 1 + 4 * j;
            wd = (a == 1) ? 32'hff7fffff : 32'hffffffff;
            for (int k = 0; k < 4; k++)
                ex[8*k+:8] = (a + k < 13) ? (ddmc_pkg::WR_MASK[a+k] & wd[8*k+:8]) : 8'h00;
            wr(5'(a), wd, 4);
            rd(5'(a), 4, rv);
            chk("burst readback", ex, rv);
        end
    endtask

    task automatic t_fields();
        logic [7:0] v;
        logic [7:0] w;
        logic       p8;
        for (int k = 0; k < 4; k++)
        begin
            v = {4{2'(k)}};
            w = ~v;
            wr(5'h01, {4{v}}, 4);
            wr(5'h05, {4{v}}, 4);
            wr(5'h09, {4{w}}, 4);
            chk("addr1 fields", {25'h0, v[7:1]}, {dut.interp_rate, dut.mod_mode, dut.zero_stuff_en,
                dut.real_mix, dut.image_sel});
            chk("addr2 fields", {v[7:5], v[1:0]}, {dut.straight_binary, dut.one_port_mode,
                dut.data_rate_clock_out_strong, dut.channel_select_invert, dut.qi_pair_order});
            chk("pll fields", {v[7:6], v[2:0], v[1:0]}, {dut.pll_en, dut.cp_manual, dut.cp_bias,
                dut.pll_div});
            chk("i trims", {v, v[3:0], v[7], v, v[1:0]}, {dut.i_fine_gain, dut.i_coarse_gain,
                dut.i_offset_dir, dut.i_offset});
            chk("q trims", {w, w[3:0], w[7], w, w[1:0]}, {dut.q_fine_gain, dut.q_coarse_gain,
                dut.q_offset_dir, dut.q_offset});
            p8 = ((v[6] | v[0]) && !v[7]) ? (dclk_in ^ v[4]) : (lock_in & v[7]);
            chk("shared pin", p8, dut.data_rate_clock_out);
            chk("one port clock", dclk_in ^ v[2], dut.single_port_clock_out);
            if (v[7])
                chk("serial out clock", 2'b11, {sdo_oe, sdo_pin});
        end
        wr(5'h03, 32'h0, 1);
    endtask

    task automatic t_power();
        int n0;
        wr(5'h00, 32'h1c, 1);
        chk("power bits", 3'b111, {dut.dac_sleep, dut.power_down, dut.resistor_mode_select});
        wr(5'h05, 32'h3c, 1);
        n0 = n_restart;
        wr(5'h00, 32'h3c, 1);
        chk("restart pulses", 1, n_restart - n0);
        chk("fine gain after soft reset", 32'h0, dut.i_fine_gain);
        chk("power bits kept", 3'b111, {dut.dac_sleep, dut.power_down, dut.resistor_mode_select});
        rd(5'h00, 1, rv);
        chk("addr0 readback", 32'h1c, rv);
        @(posedge ref_clk) srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd(5'h00, 1, rv);
        chk("addr0 after pin reset", 32'h0, rv);
    endtask

    task automatic t_lock();
        @(posedge ref_clk) lock_in <= 1'b1;
        wr(5'h04, 32'h80, 1);
        rd(5'h00, 1, rv);
        chk("locked", 32'h02, rv);
        @(posedge ref_clk) lock_in <= 1'b0;
        rd(5'h00, 1, rv);
        chk("unlocked", 32'h0, rv);
        @(posedge ref_clk) lock_in <= 1'b1;
        wr(5'h04, 32'h0, 1);
        rd(5'h00, 1, rv);
        chk("pll off", 32'h0, rv);
    endtask

    task automatic t_order();
        wr(5'h00, 32'h40, 1);
        lsb_mode = 1'b1;
        wr(5'h05, 32'h01, 1);
        chk("lsb first write", 32'h01, dut.i_fine_gain);
        rd(5'h05, 1, rv);
        chk("lsb first read", 32'h01, rv);
        wr(5'h00, 32'h0, 1);
        lsb_mode = 1'b0;
    endtask

    task automatic t_bidir();
        wr(5'h05, 32'h96, 1);
        @(negedge ref_clk) {oe_a, oe_b} = 2'b00;
        rd(5'h05, 1, rv);
        chk("unidir pins", {8'h96, 2'b01}, {rv[7:0], oe_a, oe_b});
        wr(5'h00, 32'h80, 1);
        @(negedge ref_clk) {oe_a, oe_b} = 2'b00;
        rd(5'h05, 1, rv);
        chk("bidir pins", {8'h96, 2'b10}, {rv[7:0], oe_a, oe_b});
        wr(5'h00, 32'h0, 1);
        host.xfer(1'b0, 1, 5'h05, 1'b0, 32'hee, 5, rv);
        chk("aborted byte", 32'h96, dut.i_fine_gain);
    endtask

    initial
    begin
        {srst, lock_in, dclk_in, lsb_mode, idle_t, oe_a, oe_b} = 7'b1110000;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_regs();
        t_fields();
        t_power();
        t_lock();
        t_order();
        t_bidir();
        stop_test();
    end
endmodule
